// ===== rtl/net_pin_route.sv
`timescale 1ns/100ps

// Routes the shared network-controller pins
module net_pin_route (
    // Select word
    input wire logic [15:0] sel_i,
    // Sources
    input wire logic dma_ch1_transfer_end_i,
    input wire logic dma_ch0_transfer_end_i,
    input wire logic net_general_output_i,
    input wire logic irq_five_pin_i,
    input wire logic irq_four_pin_i,
    // Routed signals
    output logic dma1_end_pin_o,
    output logic shared_out_pin_o,
    output logic interrupt_request_five_o,
    output logic interrupt_request_four_o
);

    assign dma1_end_pin_o = ~sel_i[pin_function_pkg::DMA1_END_BIT] & dma_ch1_transfer_end_i;
    // 1 network output, 0 channel-0 end
    assign shared_out_pin_o = sel_i[pin_function_pkg::NET_OUT_SEL_BIT]
        ? net_general_output_i : dma_ch0_transfer_end_i;
    assign interrupt_request_five_o = ~sel_i[pin_function_pkg::IRQ_FIVE_BIT] & irq_five_pin_i;
    assign interrupt_request_four_o = ~sel_i[pin_function_pkg::IRQ_FOUR_BIT] & irq_four_pin_i;

endmodule

// ===== rtl/pin_function_controller.sv
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps

// Notes on behaviour
// - Port B select register resets to aaaa on power-on only.
// - Port B pin n uses bits 2n+1:2n.
// - Port B codes 01 output, 10 input with pull-up, 11 input without.
// - Port B code 00 is the peripheral on pins 1-7 and reserved on pin 0.
// - Port C select register resets to aaaa on power-on only.
// - Port C uses the same 2-bit coding on all eight pins.
// - Network pin register resets to aaaa on power-on only.
// - Bit 15 at 0 routes channel-1 transfer end; 1 is reserved.
// - Bit 13 at 0 connects interrupt request five; 1 is reserved.
// - Bit 11 picks channel-0 transfer end (0) or network output (1).
// - Bit 9 at 0 connects interrupt request four; 1 is reserved.
// - Even bits of the network register read 0.
// - Bits 7, 5, 3 and 1 of the network register read 1.
// - Each pin selection stands alone, whatever the chip mode.
module pin_function_controller #(
    parameter int PINS = pin_function_pkg::PINS_PER_PORT
) (
    // Clock and power-on reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Port B pin controls
    output logic [PINS-1:0] port_b_alt_o,
    output logic [PINS-1:0] port_b_out_en_o,
    output logic [PINS-1:0] port_b_pullup_o,
    // Port C pin controls
    output logic [PINS-1:0] port_c_alt_o,
    output logic [PINS-1:0] port_c_out_en_o,
    output logic [PINS-1:0] port_c_pullup_o,
    // Shared network pins
    input wire logic dma_ch1_transfer_end_i,
    input wire logic dma_ch0_transfer_end_i,
    input wire logic net_general_output_i,
    input wire logic irq_five_pin_i,
    input wire logic irq_four_pin_i,
    output logic dma1_end_pin_o,
    output logic shared_out_pin_o,
    output logic interrupt_request_five_o,
    output logic interrupt_request_four_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2*PINS-1:0] port_b_function_select;
        logic [2*PINS-1:0] port_c_function_select;
        logic [15:0] net_shared_pin_select;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
    } state_s;

    state_s st;
    state_s next_st;
    logic addr_take;
    logic [15:0] net_read;
    logic [31:0] read_mux;

    assign addr_take = hsel_i & hready_i & (htrans_i == pin_function_pkg::HTRANS_NONSEQ);

    assign net_read = (st.net_shared_pin_select & pin_function_pkg::NET_WRITABLE_MASK)
        | pin_function_pkg::NET_FIXED_ONES;

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    always_comb
    begin
        read_mux = 32'h0;
        case (haddr_i & pin_function_pkg::ADDR_MASK)
            pin_function_pkg::PORT_B_SEL_ADDR:
                read_mux = {16'h0, st.port_b_function_select};
            pin_function_pkg::PORT_C_SEL_ADDR:
                read_mux = {16'h0, st.port_c_function_select};
            pin_function_pkg::NET_SEL_ADDR:
                read_mux = {16'h0, net_read};
            default:
                read_mux = 32'h0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        // write lands at data-phase edge, read back next cycle
        if (st.wr_pend)
        begin
            case (st.wr_addr)
                pin_function_pkg::PORT_B_SEL_ADDR:
                    next_st.port_b_function_select = hwdata_i[2*PINS-1:0];
                pin_function_pkg::PORT_C_SEL_ADDR:
                    next_st.port_c_function_select = hwdata_i[2*PINS-1:0];
                pin_function_pkg::NET_SEL_ADDR:
                    // Only selector bits stored; fixed bits come from constants
                    next_st.net_shared_pin_select =
                        hwdata_i[15:0] & pin_function_pkg::NET_WRITABLE_MASK;
                default:
                    next_st.wr_pend = 1'b0;
            endcase
        end
        next_st.wr_pend = addr_take & hwrite_i;
        next_st.wr_addr = haddr_i & pin_function_pkg::ADDR_MASK;
        if (addr_take & ~hwrite_i)
        begin
            next_st.rdata = read_mux;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // power-on value only; no other reset reaches here
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st.port_b_function_select <= pin_function_pkg::SEL_RESET;
            st.port_c_function_select <= pin_function_pkg::SEL_RESET;
            st.net_shared_pin_select <= pin_function_pkg::SEL_RESET
                & pin_function_pkg::NET_WRITABLE_MASK;
            st.wr_pend <= 1'b0;
            st.wr_addr <= 8'h0;
            st.rdata <= 32'h0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Zero wait states, always OKAY
    assign hreadyout_o = 1'b1;
    assign hresp_o = pin_function_pkg::HRESP_OKAY;
    assign hrdata_o = st.rdata;

    // ------------------------------------------------------------
    // Pin decode
    // ------------------------------------------------------------
    // per-pin, mode independent
    // pin 0 peripheral code held off
    port_pin_decode #(
        .PINS(PINS),
        .PIN0_ALT_RESERVED(1'b1)
    ) u_port_b (
        .sel_i(st.port_b_function_select),
        .alt_o(port_b_alt_o),
        .out_en_o(port_b_out_en_o),
        .pullup_o(port_b_pullup_o)
    );

    port_pin_decode #(
        .PINS(PINS),
        .PIN0_ALT_RESERVED(1'b0)
    ) u_port_c (
        .sel_i(st.port_c_function_select),
        .alt_o(port_c_alt_o),
        .out_en_o(port_c_out_en_o),
        .pullup_o(port_c_pullup_o)
    );

    // reserved 1 after reset keeps channel-1 end and interrupt requests five and four off
    net_pin_route u_net (
        .sel_i(st.net_shared_pin_select),
        .dma_ch1_transfer_end_i(dma_ch1_transfer_end_i),
        .dma_ch0_transfer_end_i(dma_ch0_transfer_end_i),
        .net_general_output_i(net_general_output_i),
        .irq_five_pin_i(irq_five_pin_i),
        .irq_four_pin_i(irq_four_pin_i),
        .dma1_end_pin_o(dma1_end_pin_o),
        .shared_out_pin_o(shared_out_pin_o),
        .interrupt_request_five_o(interrupt_request_five_o),
        .interrupt_request_four_o(interrupt_request_four_o)
    );

endmodule

// ===== rtl/pin_function_pkg.sv
package pin_function_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] PORT_B_SEL_ADDR = 8'h00;
    localparam logic [7:0] PORT_C_SEL_ADDR = 8'h04;
    localparam logic [7:0] NET_SEL_ADDR = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'hfc;

    // ------------------------------------------------------------
    // Reset values and fields
    // ------------------------------------------------------------
    localparam logic [15:0] SEL_RESET = 16'haaaa;
    localparam logic [15:0] NET_WRITABLE_MASK = 16'haa00;
    localparam logic [15:0] NET_FIXED_ONES = 16'h00aa;
    localparam int DMA1_END_BIT = 15;
    localparam int IRQ_FIVE_BIT = 13;
    localparam int NET_OUT_SEL_BIT = 11;
    localparam int IRQ_FOUR_BIT = 9;
    localparam int PINS_PER_PORT = 8;

    // ------------------------------------------------------------
    // Field codes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_ALT = 2'h0;
    localparam logic [1:0] MODE_OUT = 2'h1;
    localparam logic [1:0] MODE_IN_PULLUP = 2'h2;
    localparam logic [1:0] MODE_IN_FLOAT = 2'h3;

    // ------------------------------------------------------------
    // Bus codes
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

endpackage

// ===== rtl/port_pin_decode.sv
`timescale 1ns/100ps

// Decodes one port's select word into per-pin controls
module port_pin_decode #(
    parameter int PINS = 8,
    parameter bit PIN0_ALT_RESERVED = 1'b0
) (
    // Select word
    input wire logic [2*PINS-1:0] sel_i,
    // Per-pin controls
    output logic [PINS-1:0] alt_o,
    output logic [PINS-1:0] out_en_o,
    output logic [PINS-1:0] pullup_o
);

    genvar n;
    generate
        for (n = 0; n < PINS; n++)
        begin : g_pin
            logic [1:0] code;
            assign code = sel_i[2*n+1:2*n];
            // pin 0 code 00 reserved, kept off the peripheral
            if (n == 0 && PIN0_ALT_RESERVED)
            begin : g_res
                assign alt_o[n] = 1'b0;
            end
            else
            begin : g_alt
                assign alt_o[n] = (code == pin_function_pkg::MODE_ALT);
            end
            // 01 output, 10 pull-up input, 11 plain input
            assign out_en_o[n] = (code == pin_function_pkg::MODE_OUT);
            assign pullup_o[n] = (code == pin_function_pkg::MODE_IN_PULLUP);
        end
    endgenerate

endmodule

// ===== verif/pin_function_controller_sva.sv
`timescale 1ns/100ps

module pin_function_controller_sva #(
    parameter int PINS = 8
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Bus
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    // Port pins
    input wire logic [PINS-1:0] port_b_alt_o,
    input wire logic [PINS-1:0] port_b_out_en_o,
    input wire logic [PINS-1:0] port_b_pullup_o,
    input wire logic [PINS-1:0] port_c_pullup_o,
    // Shared pins
    input wire logic dma_ch1_transfer_end_i,
    input wire logic dma_ch0_transfer_end_i,
    input wire logic net_general_output_i,
    input wire logic irq_four_pin_i,
    input wire logic dma1_end_pin_o,
    input wire logic shared_out_pin_o,
    input wire logic interrupt_request_four_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    sequence taken(logic w, logic [7:0] a);
        hsel_i && hready_i && htrans_i == pin_function_pkg::HTRANS_NONSEQ
            && hwrite_i == w && haddr_i == a;
    endsequence
    // Ends in the data phase of a network register write
    sequence net_wr;
        taken(1'b1, pin_function_pkg::NET_SEL_ADDR) ##1 1'b1;
    endsequence
    property p_readback;
        logic [15:0] d;
        taken(1'b1, pin_function_pkg::PORT_B_SEL_ADDR) ##1 (1'b1, d = hwdata_i[15:0])
            ##1 taken(1'b0, pin_function_pkg::PORT_B_SEL_ADDR) |=> hrdata_o[15:0] == d;
    endproperty
    property p_shared;
        logic s;
        net_wr ##0 (1'b1, s = hwdata_i[11]) |=>
            shared_out_pin_o == (s ? net_general_output_i : dma_ch0_transfer_end_i);
    endproperty

    AST_POR_PULLUP: assert property (
        $rose(resetn_i) |-> port_b_pullup_o == '1 && port_c_pullup_o == '1)
        else $error("select registers not at reset value");
    AST_B_MODES: assert property (
        ((port_b_alt_o & port_b_out_en_o) | (port_b_alt_o & port_b_pullup_o)
            | (port_b_out_en_o & port_b_pullup_o)) == '0)
        else $error("port b pin has two modes at once");
    AST_B_PIN0: assert property (!port_b_alt_o[0])
        else $error("port b pin 0 set to peripheral");
    AST_NET_FIXED: assert property (
        taken(1'b0, pin_function_pkg::NET_SEL_ADDR) |=>
            (hrdata_o & 32'hffff_55ff) == 32'h0000_00aa)
        else $error("network register fixed bits wrong");
    AST_READBACK: assert property (p_readback)
        else $error("port b readback differs from write");
    AST_DMA1: assert property (
        net_wr ##0 !hwdata_i[15] |=> dma1_end_pin_o == dma_ch1_transfer_end_i)
        else $error("channel 1 end not routed");
    AST_SHARED: assert property (p_shared)
        else $error("shared output from wrong source");
    AST_INTERRUPT_REQUEST_FOUR: assert property (
        net_wr ##0 !hwdata_i[9] |=> interrupt_request_four_o == irq_four_pin_i)
        else $error("interrupt four not connected");
endmodule

bind pin_function_controller pin_function_controller_sva #(.PINS(PINS))
    i_pin_function_controller_sva (.*);

// ===== verif/pin_function_controller_tb.sv
`timescale 1ns/100ps

module pin_function_controller_tb;
    logic clk_sys_i = 0, resetn_i = 0, hsel_i = 1, hwrite_i = 0;
    logic [7:0] haddr_i = 0;
    logic [1:0] htrans_i = 0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] hwdata_i = 0, hrdata_o, rd;
    logic hready_i, hreadyout_o, hresp_o;
    logic [7:0] port_b_alt_o, port_b_out_en_o, port_b_pullup_o;
    logic [7:0] port_c_alt_o, port_c_out_en_o, port_c_pullup_o;
    logic dma_ch1_transfer_end_i = 1, dma_ch0_transfer_end_i = 1, net_general_output_i = 0;
    logic irq_five_pin_i = 1, irq_four_pin_i = 1;
    logic dma1_end_pin_o, shared_out_pin_o, interrupt_request_five_o, interrupt_request_four_o;
    logic [15:0] w, e;
    int errors = 0, compares = 0;

    assign hready_i = hreadyout_o;
    always #50 clk_sys_i = ~clk_sys_i;

    pin_function_controller i_pin_function_controller (.*);

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Starts right after an edge; the data phase drives IDLE, so back-to-back calls leave one idle cycle between transfers
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d);
        htrans_i <= pin_function_pkg::HTRANS_NONSEQ;
        haddr_i <= a;
        hwrite_i <= wr;
        @(posedge clk_sys_i iff hready_i);
        htrans_i <= 2'h0;
        hwdata_i <= {16'h0, d};
        @(posedge clk_sys_i iff hready_i);
        rd = hrdata_o;
    endtask

    task automatic por();
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i);
        for (int k = 0; k < 3; k++)
        begin
            xfer(1'b0, 8'(4 * k), 16'h0);
            chk(rd, 32'haaaa);
        end
        chk({port_b_pullup_o, port_c_pullup_o}, 16'hffff);
        chk({dma1_end_pin_o, interrupt_request_five_o, interrupt_request_four_o}, 0);
    endtask

    task automatic conclude();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        por();
        for (int i = 0; i < 4; i++)
        begin
            // Pin 0 of port B never gets the reserved code; pull-up input instead
            w = (i == 0) ? 16'h0002 : {8{i[1:0]}};
            xfer(1'b1, pin_function_pkg::PORT_C_SEL_ADDR, {8{i[1:0]}});
            xfer(1'b1, pin_function_pkg::PORT_B_SEL_ADDR, w);
            xfer(1'b0, pin_function_pkg::PORT_B_SEL_ADDR, 16'h0);
            chk(rd, {16'h0, w});
            xfer(1'b0, pin_function_pkg::PORT_C_SEL_ADDR, 16'h0);
            chk(rd, {16'h0, {8{i[1:0]}}});
            chk(port_b_alt_o, i == 0 ? 8'hfe : 8'h00);
            chk(port_c_alt_o, i == 0 ? 8'hff : 8'h00);
            chk({port_b_out_en_o, port_c_out_en_o}, i == 1 ? 16'hffff : 16'h0);
            chk({port_b_pullup_o, port_c_pullup_o},
                i == 2 ? 16'hffff : (i == 0 ? 16'h0100 : 16'h0));
        end
        xfer(1'b1, pin_function_pkg::PORT_B_SEL_ADDR, 16'h4001);
        xfer(1'b0, pin_function_pkg::PORT_B_SEL_ADDR, 16'h0);
        chk({port_b_alt_o, port_b_out_en_o}, 16'h7e81);
        for (int i = 0; i < 4; i++)
        begin
            {dma_ch1_transfer_end_i, dma_ch0_transfer_end_i, net_general_output_i,
                irq_five_pin_i, irq_four_pin_i} <= i[0] ? 5'h0b : 5'h15;
            // Fixed bits always written as they read
            w = i[1] ? 16'haaaa : (i[0] ? 16'h08aa : 16'h00aa);
            e = w;
            xfer(1'b1, pin_function_pkg::NET_SEL_ADDR, w);
            xfer(1'b0, pin_function_pkg::NET_SEL_ADDR, 16'h0);
            chk(rd, {16'h0, e});
            chk({dma1_end_pin_o, shared_out_pin_o, interrupt_request_five_o,
                interrupt_request_four_o}, {~e[15] & dma_ch1_transfer_end_i,
                e[11] ? net_general_output_i : dma_ch0_transfer_end_i,
                ~e[13] & irq_five_pin_i, ~e[9] & irq_four_pin_i});
        end
        xfer(1'b0, 8'h0c, 16'h0);
        chk(rd, 32'h0);
        por();
        conclude();
    end

    // Roughly forty times the expected run
    initial
    begin
        #(3000 * 100);
        errors++;
        conclude();
    end
endmodule
